// ---- inc/fsk_pkg.sv ----
// Constants shared by the FSK modem transmit and receive path.
// Assumes a 200 MHz system clock; all timing counts derive from it.
package fsk_pkg;
  // Clock and line rates
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BIT_BPS = 1200;
  localparam int unsigned MARK_HZ = 1200;
  localparam int unsigned SPACE_HZ = 2200;
  // Waveform table shape
  localparam int unsigned TBL_LEN = 32;
  localparam int unsigned TBL_W = 6;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned PEAK_IDX = 8;
  // Cycle counts; a bit-time rounds down to whole cycles
  localparam int unsigned BIT_CYC = CLK_HZ / BIT_BPS;
  localparam int unsigned MARK_STEP = CLK_HZ / (MARK_HZ * TBL_LEN);
  localparam int unsigned SPACE_STEP = CLK_HZ / (SPACE_HZ * TBL_LEN);
  localparam int unsigned MARK_HALF = CLK_HZ / (2 * MARK_HZ);
  localparam int unsigned SPACE_HALF = CLK_HZ / (2 * SPACE_HZ);
  localparam int unsigned HALF_THR = (MARK_HALF + SPACE_HALF) / 2;
  localparam int unsigned HALF_MIN = SPACE_HALF / 2;
  localparam int unsigned HALF_MAX_US = 550;
  localparam int unsigned HALF_MAX = (CLK_HZ / 1_000_000) * HALF_MAX_US;
  localparam int unsigned HOLD_US = 2100;
  localparam int unsigned HOLD_CYC = (CLK_HZ / 1_000_000) * HOLD_US;
  localparam int unsigned START_BITS = 5;
  localparam int unsigned CD_ON_BITS = 6;
  localparam int unsigned CNT_W = 20;
  // Carrier sense hysteresis on good half-cycles
  localparam logic [3:0] CD_MAX = 4'h8;
  localparam logic [3:0] CD_ON = 4'h8;
  localparam logic [3:0] CD_OFF = 4'h4;
  // Byte FIFOs
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PTR_W = 3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Synchroniser lanes and their reset values
  localparam int unsigned SY_SDI = 0;
  localparam int unsigned SY_CSN = 1;
  localparam int unsigned SY_SCLK = 2;
  localparam int unsigned SY_FILT = 3;
  localparam int unsigned SY_RAW = 4;
  localparam int unsigned SY_TXD = 5;
  localparam int unsigned SY_RTSN = 6;
  localparam int unsigned SY_IFSEL = 7;
  localparam int unsigned SY_W = 8;
  localparam logic [7:0] SYNC_RST = 8'h62;
  typedef logic signed [TBL_W-1:0] fsk_sample_t;
endpackage

// ---- inc/fsk_tbl_if.sv ----
// Link between the modulator and its waveform table.
// Assumes the table answers one clock after the address.
`timescale 1ns/1ps
interface fsk_tbl_if;
  logic [fsk_pkg::IDX_W-1:0] addr;
  fsk_pkg::fsk_sample_t data;
  modport user (output addr, input data);
  modport rom (input addr, output data);
endinterface // fsk_tbl_if

// ---- hw/fsk_sine_rom.sv ----
// One sine period of 32 signed 6-bit samples, registered read.
// Assumes the synchronous active-low reset of the modem clock domain.
`timescale 1ns/1ps
module fsk_sine_rom (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  fsk_tbl_if.rom tbl
);
  import fsk_pkg::*;

  fsk_sample_t data_d;
  fsk_sample_t data_q;

  // Quarter wave; the other three quarters come by symmetry
  function automatic fsk_sample_t quarter(input logic [3:0] k);
    case (k)
      4'h0: quarter = 6'sd0;
      4'h1: quarter = 6'sd6;
      4'h2: quarter = 6'sd12;
      4'h3: quarter = 6'sd17;
      4'h4: quarter = 6'sd22;
      4'h5: quarter = 6'sd26;
      4'h6: quarter = 6'sd29;
      4'h7: quarter = 6'sd30;
      default: quarter = 6'sd31;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Fold index onto the quarter wave
  always_comb begin
    logic [3:0] half_idx;
    logic [3:0] k;
    half_idx = tbl.addr[3:0];
    k = (half_idx > 4'h8) ? 4'(5'h10 - {1'b0, half_idx}) : half_idx;
    data_d = tbl.addr[4] ? -quarter(k) : quarter(k); // see [R4]
  end

  // Read data leave from a register
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      data_q <= '0;
    end else begin
      data_q <= data_d;
    end
  end

  assign tbl.data = data_q;
endmodule // fsk_sine_rom

// ---- hw/fsk_modem.sv ----
// FSK modulator and demodulator path with UART pass-through and SPI FIFOs.
// Assumes pins arrive asynchronously; config bits come from the same clock.
//
// Operation
// [R1] SPI mode: bytes written over SPI fill a transmit FIFO feeding the modulator.
// [R2] UART mode: transmit FIFO bypassed, UART line bits go straight to modulator.
// [R3] Mark (one) is a 1200 Hz tone, space (zero) a 2200 Hz tone.
// [R4] Waveform table holds 32 signed 6-bit samples of one sine period.
// [R5] Index steps once per step period picked by data bit; phase stays continuous.
// [R6] Unless full duplex, modulator and demodulator never run together.
// [R7] UART host pulls request-to-send pin low to transmit, high to stop.
// [R8] SPI host requests transmit with the request-to-send control bit.
// [R9] SPI mode: demodulated bits from raw or filtered input fill a receive FIFO.
// [R10] UART mode: demodulated bits drive the UART receive output unbuffered.
// [R11] UART mode: carrier sense output is high while a valid carrier is seen.
// [R12] SPI mode: carrier detection toggles the interrupt and sets the carrier flag.
// [R13] Carrier sensing uses hysteresis against marginal or fluctuating input.
// [R14] Carrier reaches its first peak within 5 bit-times of request.
// [R15] Carrier falls below receive amplitude within 3 bit-times of release.
// [R16] Carrier reaches zero within 6 bit-times of release.
// [R17] Carrier sense asserts within 6 bit-times of a valid carrier.
// [R18] Carrier sense drops within 3 ms of carrier removal.
// [R19] After transmit ends, wait at least 2.1 ms before sensing carrier.
// [R20] SPI host keeps chip select high at least 3.06 us between frames.
// [R21] Host waits 30 us after power-down before expecting operation.
// [R22] SPI data output shifts input through, allowing daisy chaining.
// [R23] One bit-time is one period of 1200 bit/s from the system clock.
`timescale 1ns/1ps
module fsk_modem #(
  parameter int unsigned BIT_CYC = fsk_pkg::BIT_CYC,
  parameter int unsigned MARK_STEP = fsk_pkg::MARK_STEP,
  parameter int unsigned HALF_THR = fsk_pkg::HALF_THR,
  parameter int unsigned HALF_MIN = fsk_pkg::HALF_MIN,
  parameter int unsigned HALF_MAX = fsk_pkg::HALF_MAX,
  parameter int unsigned HOLD_CYC = fsk_pkg::HOLD_CYC
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic if_sel_in,
  input wire logic full_duplex_in,
  input wire logic rts_bit_in,
  input wire logic rx_filt_sel_in,
  input wire logic flag_clr_in,
  input wire logic rts_n_in,
  input wire logic uart_txd_in,
  input wire logic analog_rx_in,
  input wire logic filtered_rx_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic signed [fsk_pkg::TBL_W-1:0] analog_tx_out,
  output logic tx_active_out,
  output logic uart_rxd_out,
  output logic carrier_sense_out,
  output logic irq_out,
  output logic carrier_flag_bit_out,
  output logic sdo_out,
  output logic sdo_oe_out
);
  import fsk_pkg::*;
  // Space step scales with the mark step so shortened counts keep the tone ratio
  localparam int unsigned SP_STEP = MARK_STEP * MARK_HZ / SPACE_HZ;

  ////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin
  logic [SY_W-1:0] s1_q, s2_q, s3_q, pin_async;
  assign pin_async = {if_sel_in, rts_n_in, uart_txd_in, analog_rx_in,
                      filtered_rx_in, sclk_in, cs_n_in, sdi_in};
  // Third stage only feeds edge detectors, never the first flop
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic spi, rx_in, rx_prev, sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign spi = s2_q[SY_IFSEL];
  assign rx_in = rx_filt_sel_in ? s2_q[SY_FILT] : s2_q[SY_RAW]; // see [R9]
  assign rx_prev = rx_filt_sel_in ? s3_q[SY_FILT] : s3_q[SY_RAW];
  assign sclk_rise = s2_q[SY_SCLK] & ~s3_q[SY_SCLK];
  assign sclk_fall = ~s2_q[SY_SCLK] & s3_q[SY_SCLK];
  assign cs_fall = ~s2_q[SY_CSN] & s3_q[SY_CSN];
  assign cs_rise = s2_q[SY_CSN] & ~s3_q[SY_CSN];

  ////////////////////////////////////////////////////////////////////
  // Bit-time tick, free running
  logic [CNT_W-1:0] btim_d, btim_q;
  logic bit_tick;
  assign bit_tick = (btim_q == CNT_W'(BIT_CYC - 1)); // see [R23]
  always_comb begin
    btim_d = bit_tick ? '0 : btim_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // SPI shifter, byte FIFOs, transmit and receive state
  logic [7:0] sh_d, sh_q, txsh_d, txsh_q, rxsh_d, rxsh_q;
  logic [3:0] sbits_d, sbits_q, txn_d, txn_q, rxn_d, rxn_q, hys_d, hys_q;
  logic sdo_d, sdo_q, sdo_oe_d, sdo_oe_q;
  logic [7:0] txf_d [FIFO_DEPTH];
  logic [7:0] txf_q [FIFO_DEPTH];
  logic [7:0] rxf_d [FIFO_DEPTH];
  logic [7:0] rxf_q [FIFO_DEPTH];
  logic [PTR_W-1:0] txw_d, txw_q, txr_d, txr_q, rxw_d, rxw_q, rxr_d, rxr_q;
  logic tx_on_d, tx_on_q, tx_req, rx_act, tx_bit;
  logic [IDX_W-1:0] idx_d, idx_q;
  logic [CNT_W-1:0] step_d, step_q, gap_d, gap_q, hold_d, hold_q;
  fsk_sample_t dac_d, dac_q;
  logic cd_d, cd_q, rbit_d, rbit_q, rxd_d, rxd_q, irq_d, irq_q, flag_d, flag_q;
  logic sense_d, sense_q;
  fsk_tbl_if tbl ();

  // FIFO occupancy tests are used on both FIFOs
  function automatic logic is_full(input logic [PTR_W-1:0] w, r);
    is_full = (w[PTR_W-1] != r[PTR_W-1]) && (w[PTR_W-2:0] == r[PTR_W-2:0]);
  endfunction
  function automatic logic is_empty(input logic [PTR_W-1:0] w, r);
    is_empty = (w == r);
  endfunction

  // Request source depends on interface; arbitration blocks tx during rx
  assign tx_req = spi ? rts_bit_in : ~s2_q[SY_RTSN]; // see [R7] see [R8]
  assign rx_act = ~tx_on_q | full_duplex_in;

  // Modulator bit: UART line bypasses the FIFO, SPI shifts FIFO bytes
  assign tx_bit = spi ? ((txn_q != 4'h0) ? txsh_q[0] : 1'b1)
                      : s2_q[SY_TXD]; // see [R2]

  assign tbl.addr = idx_q;

  ////////////////////////////////////////////////////////////////////
  // Transmit path
  always_comb begin
    logic [CNT_W-1:0] lim;
    lim = tx_bit ? CNT_W'(MARK_STEP) : CNT_W'(SP_STEP); // see [R3]
    tx_on_d = tx_req && (tx_on_q || full_duplex_in || !cd_q); // see [R6]
    step_d = '0;
    idx_d = '0;
    if (tx_on_q) begin
      // Compare with >= so a bit change mid-step keeps phase
      if (step_q >= lim - 1'b1) begin
        idx_d = idx_q + 1'b1; // see [R5]
      end else begin
        step_d = step_q + 1'b1;
        idx_d = idx_q;
      end
    end
    // Output forced to zero the cycle after release
    dac_d = tx_on_q ? tbl.data : '0; // see [R15] see [R16]
    hold_d = (tx_on_q && !tx_on_d) ? CNT_W'(HOLD_CYC) :
             (hold_q != '0) ? hold_q - 1'b1 : '0; // see [R19]
    txsh_d = txsh_q;
    txn_d = txn_q;
    txr_d = txr_q;
    if (spi && tx_on_q && bit_tick) begin
      if (txn_q > 4'h1) begin
        txsh_d = {1'b0, txsh_q[7:1]};
        txn_d = txn_q - 1'b1;
      end else if (!is_empty(txw_q, txr_q)) begin
        txsh_d = txf_q[txr_q[PTR_W-2:0]]; // see [R1]
        txn_d = BYTE_BITS;
        txr_d = txr_q + 1'b1;
      end else begin
        txn_d = 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Demodulator: half-period measurement and carrier hysteresis
  always_comb begin
    logic edge_seen;
    edge_seen = (rx_in != rx_prev);
    gap_d = gap_q + 1'b1;
    hys_d = hys_q;
    rbit_d = rbit_q;
    if (!rx_act || hold_q != '0) begin
      gap_d = '0;
      hys_d = '0;
    end else if (edge_seen) begin
      gap_d = '0;
      if (gap_q >= CNT_W'(HALF_MIN) && gap_q < CNT_W'(HALF_MAX)) begin
        rbit_d = (gap_q >= CNT_W'(HALF_THR)); // Long half-cycle is mark
        hys_d = (hys_q < CD_MAX) ? hys_q + 1'b1 : hys_q; // see [R17]
      end else if (hys_q != 4'h0) begin
        hys_d = hys_q - 1'b1;
      end
    end else if (gap_q == CNT_W'(HALF_MAX - 1)) begin
      // Silence counts as a lost half-cycle; bounds the drop time
      gap_d = '0;
      hys_d = (hys_q != 4'h0) ? hys_q - 1'b1 : hys_q; // see [R18]
    end
    // Separate on and off levels keep a marginal carrier from chattering
    cd_d = (hys_q >= CD_ON) ? 1'b1 : (hys_q <= CD_OFF) ? 1'b0 : cd_q; // see [R13]
    rxd_d = (cd_q && !spi) ? rbit_q : 1'b1; // see [R10]
    sense_d = cd_d && !spi; // see [R11]
    irq_d = (spi && cd_d && !cd_q) ? ~irq_q : irq_q; // see [R12]
    // Set wins over a clear in the same cycle
    flag_d = (spi && cd_d && !cd_q) ? 1'b1 : (flag_clr_in ? 1'b0 : flag_q);
    rxsh_d = rxsh_q;
    rxn_d = cd_q ? rxn_q : 4'h0;
    if (spi && cd_q && bit_tick) begin
      rxsh_d = {rbit_q, rxsh_q[7:1]};
      rxn_d = (rxn_q == BYTE_BITS - 1'b1) ? 4'h0 : rxn_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // SPI shifter and FIFO pointers
  always_comb begin
    logic rx_push;
    rx_push = 1'b0;
    txf_d = txf_q;
    rxf_d = rxf_q;
    txw_d = txw_q;
    rxw_d = rxw_q;
    rxr_d = rxr_q;
    sh_d = sh_q;
    sbits_d = sbits_q;
    sdo_d = sdo_q;
    sdo_oe_d = ~s2_q[SY_CSN];
    if (cs_fall) begin
      sbits_d = 4'h0;
      if (spi && !is_empty(rxw_q, rxr_q)) begin
        sh_d = rxf_q[rxr_q[PTR_W-2:0]];
        rxr_d = rxr_q + 1'b1;
      end else begin
        sh_d = '0;
      end
    end else if (!s2_q[SY_CSN]) begin
      // Out on rising edge, in on falling edge; eight-bit delay chains
      if (sclk_rise) begin
        sdo_d = sh_q[7]; // see [R22]
      end
      if (sclk_fall) begin
        sh_d = {sh_q[6:0], s2_q[SY_SDI]};
        sbits_d = (sbits_q < BYTE_BITS) ? sbits_q + 1'b1 : sbits_q;
      end
    end
    // Last eight bits of a frame are this device's byte
    if (cs_rise && spi && sbits_q == BYTE_BITS && !is_full(txw_q, txr_q)) begin
      txf_d[txw_q[PTR_W-2:0]] = sh_q; // see [R1]
      txw_d = txw_q + 1'b1;
    end
    // A full receive FIFO drops new bytes rather than overwrite
    rx_push = spi && cd_q && bit_tick && (rxn_q == BYTE_BITS - 1'b1);
    if (rx_push && !is_full(rxw_q, rxr_d)) begin
      rxf_d[rxw_q[PTR_W-2:0]] = {rbit_q, rxsh_q[7:1]}; // see [R9]
      rxw_d = rxw_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      btim_q <= '0;
      tx_on_q <= 1'b0;
      step_q <= '0;
      idx_q <= '0;
      dac_q <= '0;
      hold_q <= '0;
      txsh_q <= '0;
      txn_q <= '0;
      gap_q <= '0;
      hys_q <= '0;
      rbit_q <= 1'b1;
      cd_q <= 1'b0;
      sense_q <= 1'b0;
      rxd_q <= 1'b1;
      irq_q <= 1'b0;
      flag_q <= 1'b0;
      rxsh_q <= '0;
      rxn_q <= '0;
      sh_q <= '0;
      sbits_q <= '0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      txw_q <= '0;
      txr_q <= '0;
      rxw_q <= '0;
      rxr_q <= '0;
      txf_q <= '{default: '0};
      rxf_q <= '{default: '0};
    end else begin
      btim_q <= btim_d;
      tx_on_q <= tx_on_d;
      step_q <= step_d;
      idx_q <= idx_d;
      dac_q <= dac_d;
      hold_q <= hold_d;
      txsh_q <= txsh_d;
      txn_q <= txn_d;
      gap_q <= gap_d;
      hys_q <= hys_d;
      rbit_q <= rbit_d;
      cd_q <= cd_d;
      sense_q <= sense_d;
      rxd_q <= rxd_d;
      irq_q <= irq_d;
      flag_q <= flag_d;
      rxsh_q <= rxsh_d;
      rxn_q <= rxn_d;
      sh_q <= sh_d;
      sbits_q <= sbits_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      txw_q <= txw_d;
      txr_q <= txr_d;
      rxw_q <= rxw_d;
      rxr_q <= rxr_d;
      txf_q <= txf_d;
      rxf_q <= rxf_d;
    end
  end

  fsk_sine_rom u_rom (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .tbl(tbl)
  );

  // Outputs straight from flops
  assign analog_tx_out = dac_q;
  assign tx_active_out = tx_on_q;
  assign uart_rxd_out = rxd_q;
  assign carrier_sense_out = sense_q;
  assign irq_out = irq_q;
  assign carrier_flag_bit_out = flag_q;
  assign sdo_out = sdo_q;
  assign sdo_oe_out = sdo_oe_q;

  ////////////////////////////////////////////////////////////////////
  // Checks; helper counter of cycles from request to first peak
  logic [CNT_W+2:0] start_q;
  logic peak_q;
  // Stops at the first peak so later wraps of the index do not count
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || !tx_on_q) begin
      start_q <= '0;
      peak_q <= 1'b0;
    end else if (!peak_q) begin
      peak_q <= (idx_q == IDX_W'(PEAK_IDX));
      start_q <= start_q + 1'b1;
    end
  end
  logic [CNT_W+2:0] cdon_q;
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || hys_q == 4'h0 || cd_q) begin
      cdon_q <= '0;
    end else begin
      cdon_q <= cdon_q + 1'b1;
    end
  end

  sequence rel_s;
    tx_on_q ##1 !tx_on_q;
  endsequence

  first_peak_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R14]
    start_q <= (CNT_W+3)'(START_BITS * BIT_CYC))
    else $error("carrier first peak late");
  tx_zero_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R16]
    rel_s |=> (analog_tx_out == '0) [*3])
    else $error("carrier not zero after release");
  half_duplex_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R6]
    (!full_duplex_in && tx_on_q) |-> (!cd_q && hys_q == 4'h0))
    else $error("tx and rx active together");
  idx_step_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R5]
    (tx_on_q && tx_on_d && step_q != '0) |=> (idx_q == $past(idx_q) + 1'b1 || step_q != '0))
    else $error("table index skipped");
  cd_hyst_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R13]
    $rose(cd_q) |-> $past(hys_q) >= CD_ON)
    else $error("carrier sensed below on level");
  cd_on_time_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R17]
    cdon_q <= (CNT_W+3)'(CD_ON_BITS * BIT_CYC))
    else $error("carrier sense assert late");
  hold_off_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R19]
    rel_s |=> (!cd_q && hold_q == CNT_W'(HOLD_CYC - 1)))
    else $error("holdoff not started");
  flag_set_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R12]
    (spi && $rose(cd_q)) |-> (flag_q && irq_q != $past(irq_q)))
    else $error("carrier flag or irq missed");
  uart_pass_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // see [R10]
    (!spi && cd_q) |=> uart_rxd_out == $past(rbit_q))
    else $error("uart rx not passed through");
endmodule // fsk_modem

// ---- tb/fsk_host_model.sv ----
// Host controller model: SPI master that frames bytes for the modem.
// Assumes the bench system clock for timing; SPI clock idles low between frames.
`timescale 1ns/1ps
module fsk_host_model (
  input wire logic sys_clk_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  ////////////////////////////////////////////////////////////////
  // Idle bus: chip select high, clock still
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // Step whole system cycles, then move off the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask

  // One frame, MSB first; 16 cycles per SPI clock gives an 80 ns period
  task automatic xfer(input int nbits, input logic [15:0] wr, output logic [15:0] rd);
    rd = '0;
    cs_n_out = 1'b0;
    cyc(16);
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi_out = wr[i];
      cyc(4);
      sclk_out = 1'b1;
      cyc(8);
      rd = {rd[14:0], sdo_in};
      sclk_out = 1'b0;
      cyc(4);
    end
    cyc(8);
    cs_n_out = 1'b1;
    // Released data line must not keep showing the last bit
    sdi_out = ~sdi_out;
    cyc(620);
  endtask
endmodule // fsk_host_model

// ---- tb/fsk_modem_tx_rx_path_tb.sv ----
// Self-checking bench for the FSK modem path: receive rows, then hand tests.
// Assumes fsk_modem with shortened counts and the host SPI model beside it.
`timescale 1ns/1ps
module fsk_modem_tx_rx_path_tb;
  import fsk_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Shortened counts keep the real ratios; 3 ms is 3.6 bit-times
  localparam int BIT = 200;
  localparam int MSTEP = 6;
  localparam int HOLD = 504;
  localparam int OFF = 720;
  localparam int MPER = 32 * MSTEP;
  localparam int SPER = MPER * MARK_HZ / SPACE_HZ;
  typedef struct {logic spi; logic filt; int half; logic sense; logic bitv;} fsk_row_t;
  fsk_row_t rows [5] = '{
    '{1'b0, 1'b0, 100, 1'b1, 1'b1},
    '{1'b0, 1'b1, 54, 1'b1, 1'b0},
    '{1'b0, 1'b0, 15, 1'b0, 1'b1},
    '{1'b0, 1'b1, 200, 1'b0, 1'b1},
    '{1'b1, 1'b1, 100, 1'b1, 1'b1}};
  logic clk, rstn, if_sel, fdx, rts_bit, filt_sel, flag_clr, rts_n, txd;
  logic sclk, cs_n, sdi, tx_act, rxd, cd, irq, flag, sdo, sdo_oe, irq0, pk;
  logic car_line = 1'b0;
  logic noise = 1'b0;
  fsk_sample_t tx_out, prev;
  logic [15:0] rd;
  int fail_count, total_checks, car_half, n, p;

  ////////////////////////////////////////////////////////////////
  // Clock, line carrier and a too-fast noise line on the unused input
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial forever begin
    if (car_half > 0) begin
      repeat (car_half) @(posedge clk);
      #1 car_line = ~car_line;
    end else @(posedge clk);
  end
  always @(posedge clk) noise <= ~noise;

  fsk_host_model host (
    .sys_clk_in(clk),
    .sdo_in(sdo),
    .sclk_out(sclk),
    .cs_n_out(cs_n),
    .sdi_out(sdi)
  );

  fsk_modem #(.BIT_CYC(BIT), .MARK_STEP(MSTEP), .HALF_THR(77), .HALF_MIN(27),
    .HALF_MAX(132), .HOLD_CYC(HOLD)) dut (
    .sys_clk_in(clk),
    .resetn_in(rstn),
    .if_sel_in(if_sel),
    .full_duplex_in(fdx),
    .rts_bit_in(rts_bit),
    .rx_filt_sel_in(filt_sel),
    .flag_clr_in(flag_clr),
    .rts_n_in(rts_n),
    .uart_txd_in(txd),
    .analog_rx_in(filt_sel ? noise : car_line),
    .filtered_rx_in(filt_sel ? car_line : noise),
    .sclk_in(sclk),
    .cs_n_in(cs_n),
    .sdi_in(sdi),
    .analog_tx_out(tx_out),
    .tx_active_out(tx_act),
    .uart_rxd_out(rxd),
    .carrier_sense_out(cd),
    .irq_out(irq),
    .carrier_flag_bit_out(flag),
    .sdo_out(sdo),
    .sdo_oe_out(sdo_oe)
  );

  ////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input int k);
    rstn = 1'b0;
    cyc(k);
    rstn = 1'b1;
    cyc(4);
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return cd;
      1: return flag;
      default: return tx_act;
    endcase
  endfunction
  // Bounded wait; n equals lim when the level never came
  task automatic wait_sig(input int sel, input logic want, input int lim, output int k);
    k = 0;
    while (k < lim && pick(sel) !== want) begin
      cyc(1);
      k++;
    end
  endtask
  // Cycles between two rising zero crossings of the DAC samples
  task automatic meas(output int per);
    int k;
    bit seen;
    fsk_sample_t last;
    per = 0;
    k = 0;
    seen = 1'b0;
    last = tx_out;
    while (k < 2000 && per == 0) begin
      cyc(1);
      k++;
      if (last < 0 && tx_out >= 0) begin
        if (seen) per = k;
        seen = 1'b1;
        k = 0;
      end
      last = tx_out;
    end
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rstn, if_sel, fdx, rts_bit, filt_sel, flag_clr} = '0;
    rts_n = 1'b1;
    txd = 1'b1;
    do_reset(12);
    check(tx_out === '0 && tx_act === 1'b0 && rxd === 1'b1 && cd === 1'b0, "reset outputs");
    check(irq === 1'b0 && flag === 1'b0 && sdo_oe === 1'b0, "reset flags");
    // Receive rows: tone, bad half lengths, both inputs, both modes
    foreach (rows[i]) begin
      if_sel = rows[i].spi;
      filt_sel = rows[i].filt;
      do_reset(3);
      irq0 = irq;
      car_half = rows[i].half;
      wait_sig(int'(rows[i].spi), 1'b1, 6 * BIT + 40, n);
      check((n < 6 * BIT + 40) == rows[i].sense, "carrier sense decision");
      if (rows[i].sense && rows[i].spi) begin
        check(irq !== irq0 && cd === 1'b0, "spi carrier event");
        cyc(10 * BIT);
        car_half = 0;
        cyc(OFF);
        flag_clr = 1'b1;
        cyc(1);
        flag_clr = 1'b0;
        cyc(1);
        check(flag === 1'b0, "carrier flag clear");
        host.xfer(8, 16'h0000, rd);
        check(rd[7:0] === 8'hFF, "receive fifo byte");
      end else if (rows[i].sense) begin
        cyc(BIT);
        check(rxd === rows[i].bitv, "uart receive bit");
        car_half = 0;
        wait_sig(0, 1'b0, OFF, n);
        check(n < OFF, "carrier sense drop late");
      end
      car_half = 0;
    end
    // UART transmit: start, both tones, half duplex, hold-off
    if_sel = 1'b0;
    filt_sel = 1'b0;
    do_reset(3);
    rts_n = 1'b0;
    prev = tx_out;
    pk = 1'b0;
    n = 0;
    while (n < 5 * BIT && !pk) begin
      cyc(1);
      n++;
      pk = (prev > 0 && tx_out < prev);
      prev = tx_out;
    end
    check(pk, "first carrier peak late");
    meas(p);
    check(p == MPER, "mark tone period");
    txd = 1'b0;
    cyc(BIT);
    meas(p);
    check(p >= SPER - 16 && p <= SPER + 16, "space tone period");
    car_half = BIT / 2;
    wait_sig(0, 1'b1, 6 * BIT, n);
    check(n == 6 * BIT, "sense while transmitting");
    rts_n = 1'b1;
    wait_sig(2, 1'b0, 3 * BIT, n);
    cyc(2);
    check(n < 3 * BIT && tx_out === '0, "carrier not stopped");
    wait_sig(0, 1'b1, HOLD + 6 * BIT, n);
    check(n >= HOLD - 8 && n < HOLD + 6 * BIT, "hold-off after transmit");
    rts_n = 1'b0;
    wait_sig(2, 1'b1, 400, n);
    check(n == 400, "transmit granted over carrier");
    fdx = 1'b1;
    wait_sig(2, 1'b1, 20, n);
    check(n < 20, "full duplex refused");
    rstn = 1'b0;
    cyc(2);
    check(tx_act === 1'b0 && tx_out === '0 && cd === 1'b0, "reset in mid transmit");
    {rts_n, fdx, rstn} = 3'b101;
    car_half = 0;
    // SPI: daisy chain, then FIFO-fed transmit
    if_sel = 1'b1;
    do_reset(3);
    host.xfer(16, 16'hA53C, rd);
    check(rd[7:0] === 8'hA5, "daisy chain output");
    do_reset(3);
    host.xfer(8, 16'h0000, rd);
    host.xfer(8, 16'h0000, rd);
    rts_bit = 1'b1;
    wait_sig(2, 1'b1, 10, n);
    check(n < 10, "spi transmit not started");
    cyc(2 * BIT);
    meas(p);
    check(p >= SPER - 16 && p <= SPER + 16, "fifo data tone");
    cyc(16 * BIT);
    meas(p);
    check(p == MPER, "empty fifo tone");
    rts_bit = 1'b0;
    wait_sig(2, 1'b0, 3 * BIT, n);
    check(n < 3 * BIT, "spi transmit not stopped");
    report_and_stop;
  end
endmodule // fsk_modem_tx_rx_path_tb
